// >>> core/fsp_params.svh
// Bit positions, command codes and timing counts of the status/protect block
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// Status register fields
`define FSP_SR_SRWD 7
`define FSP_SR_PROT3 6
`define FSP_SR_TB 5
`define FSP_SR_PROT2 4
`define FSP_SR_PROT0 2
`define FSP_SR_WEL 1
`define FSP_SR_BUSY 0
`define FSP_SR_NV_RESET 6'h00

// Flag status register fields
`define FSP_FS_READY 7
`define FSP_FS_ERASE_ERR 5
`define FSP_FS_PROG_ERR 4
`define FSP_FS_PROT_ERR 1

// Array map: 27-bit byte address, 64KB sectors, 2048 of them
`define FSP_ADDR_W 27
`define FSP_ARRAY_END 27'h7FFFFFF
`define FSP_SECTOR_HI 26
`define FSP_SECTOR_LO 16
`define FSP_SUB32_LO 15
`define FSP_SUB4_LO 12
`define FSP_SECTOR_COUNT 12'h800
`define FSP_SUB4_LAST 15'h7FFF
`define FSP_PROT_ALL 4'hC

// Serial command codes (defaults, adjustable)
`define FSP_CMD_WREN 8'h06
`define FSP_CMD_WRDI 8'h04
`define FSP_CMD_RDSR 8'h05
`define FSP_CMD_WRSR 8'h01
`define FSP_CMD_RDFS 8'h70
`define FSP_CMD_CLFS 8'h50

// Status write cycle time
`define FSP_CLK_NS 10
`define FSP_TW_NS 1000
`define FSP_TW_CYC ((`FSP_TW_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// >>> core/fsp_pkg.sv
// Types shared by the status/protect block
package fsp_pkg;

    typedef enum logic [2:0] {
        FSP_OP_PROGRAM = 3'h0,
        FSP_OP_ERASE_4K = 3'h1,
        FSP_OP_ERASE_32K = 3'h2,
        FSP_OP_ERASE_SECTOR = 3'h3,
        FSP_OP_ERASE_DIE = 3'h4
    } fsp_op_e;

    typedef struct packed {
        fsp_op_e kind;
        logic [26:0] addr;
    } fsp_req_s;

    typedef struct packed {
        logic srwd;
        logic prot3;
        logic tb;
        logic [2:0] prot_lo;
        logic wel;
        logic busy;
    } fsp_status_s;

    typedef enum logic [3:0] {
        FSP_ST_OPC = 4'h1,
        FSP_ST_WDATA = 4'h2,
        FSP_ST_RDATA = 4'h4,
        FSP_ST_SKIP = 4'h8
    } fsp_spi_state_e;

endpackage

// >>> core/fsp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module fsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

`default_nettype wire

// >>> core/fsp_prot_decode.sv
// Block protect code to protected-sector decision
`include "fsp_params.svh"
`timescale 1ns/1ns
`default_nettype none

module fsp_prot_decode (
    input wire logic [3:0] block_protect_bits,
    input wire logic tb,
    input wire logic [10:0] sector,
    output logic any_set,
    output logic hit
);
    logic [11:0] span;

    always_comb begin
        span = 12'h000;
        any_set = (block_protect_bits != 4'h0);
        if (!any_set) begin
            hit = 1'b0;
        end else if (block_protect_bits >= `FSP_PROT_ALL) begin
            hit = 1'b1;
        end else begin
            span = 12'(12'h001 << (block_protect_bits - 4'h1));
            if (tb) begin
                hit = ({1'b0, sector} < span);
            end else begin
                hit = ({1'b0, sector} >= (`FSP_SECTOR_COUNT - span));
            end
        end
    end
endmodule

`default_nettype wire

// >>> core/fsp_status_protect.sv
// Status register, write protect lock and array protection of a serial flash
// Operation
// - Array is 4KB/32KB subsectors and 64KB sectors; top 4KB is 32767.
// - Status register reached only by status read and status write commands.
// - Lock bit set with write-protect pin low ignores status writes.
// - Only raising the write-protect pin or a reset releases the hardware lock.
// - Bit 7 is the status write disable bit, default 0.
// - Bit 5 anchors protection at top (0, default) or bottom (1).
// - Protect bits at 6 and 4:2 block program/erase in protected area.
// - Write enable latch clears at reset; needed before any write.
// - Bit 0 shows busy during status write, program or erase.
// - Die erase runs only when all protect bits are zero.
// - Status bit 0 is always the inverse of flag ready bit.
// - Top anchoring: code n protects top 2^(n-1) sectors; 12-15 all.
// - Bottom anchoring: code n protects lowest 2^(n-1) sectors; 12-15 all.
// - Blocked program/erase with the latch set sets flag protection error bit 1.
// - Flag bit 7 reads 0 while busy, 1 when ready.
`include "fsp_params.svh"
`timescale 1ns/1ns
`default_nettype none

module fsp_status_protect (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_dq0,
    output logic spi_dq1_o,
    output logic spi_dq1_oe,
    input wire logic wp_n,
    input wire logic req_valid,
    input wire fsp_pkg::fsp_req_s req,
    output logic req_ready,
    output logic op_start,
    output logic op_reject,
    input wire logic op_active,
    output logic write_enable_latch,
    output logic [7:0] status_protection_register,
    output logic [7:0] flag_status
);
    logic [3:0] pins_s;
    logic s_sck;
    logic s_cs_n;
    logic s_dq0;
    logic s_wp_n;

    fsp_sync #(
        .W(4),
        .RST_VAL(4'h9)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d({spi_cs_n, spi_dq0, spi_sck, wp_n}),
        .q(pins_s)
    );

    assign s_cs_n = pins_s[3];
    assign s_dq0 = pins_s[2];
    assign s_sck = pins_s[1];
    assign s_wp_n = pins_s[0];

    // Edge detection on synchronised copies only
    logic sck_d_ff;
    logic cs_d_ff;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            sck_d_ff <= s_sck;
            cs_d_ff <= s_cs_n;
        end
    end

    assign sck_rise = s_sck & ~sck_d_ff & ~s_cs_n;
    assign sck_fall = ~s_sck & sck_d_ff & ~s_cs_n;
    assign cs_rise = s_cs_n & ~cs_d_ff;

    // Register state
    logic srwd_ff;
    logic tb_ff;
    logic [3:0] blk_prot_ff;
    logic wel_ff;
    logic [7:0] wtimer_ff;
    logic prot_err_ff;
    logic erase_err_ff;
    logic prog_err_ff;
    logic busy;
    logic hw_locked;
    fsp_pkg::fsp_status_s sr;

    assign busy = op_active | (wtimer_ff != 8'h00);
    assign hw_locked = srwd_ff & ~s_wp_n;

    assign flag_status = {~busy, 1'b0, erase_err_ff, prog_err_ff, 1'b0,
                          1'b0, prot_err_ff, 1'b0};
    assign sr.srwd = srwd_ff;
    assign sr.prot3 = blk_prot_ff[3];
    assign sr.tb = tb_ff;
    assign sr.prot_lo = blk_prot_ff[2:0];
    assign sr.wel = wel_ff;
    assign sr.busy = ~flag_status[`FSP_FS_READY];
    assign status_protection_register = sr;
    assign write_enable_latch = wel_ff;

    // Serial command framing, mode 0
    fsp_pkg::fsp_spi_state_e st_ff;
    logic [2:0] bcnt_ff;
    logic [7:0] rx_ff;
    logic [7:0] cmd_ff;
    logic [7:0] wdata_ff;
    logic opc_done_ff;
    logic got_data_ff;
    logic [7:0] opc_now;

    assign opc_now = {rx_ff[6:0], s_dq0};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_ff <= fsp_pkg::FSP_ST_OPC;
            bcnt_ff <= 3'h0;
            rx_ff <= 8'h00;
            cmd_ff <= 8'h00;
            wdata_ff <= 8'h00;
            opc_done_ff <= 1'b0;
            got_data_ff <= 1'b0;
        end else if (s_cs_n) begin
            st_ff <= fsp_pkg::FSP_ST_OPC;
            bcnt_ff <= 3'h0;
            opc_done_ff <= 1'b0;
            got_data_ff <= 1'b0;
        end else if (sck_rise) begin
            rx_ff <= opc_now;
            bcnt_ff <= bcnt_ff + 3'h1;
            case (st_ff)
                fsp_pkg::FSP_ST_OPC: begin
                    if (bcnt_ff == 3'h7) begin
                        cmd_ff <= opc_now;
                        opc_done_ff <= 1'b1;
                        if (opc_now == `FSP_CMD_RDSR ||
                            opc_now == `FSP_CMD_RDFS) begin
                            st_ff <= fsp_pkg::FSP_ST_RDATA;
                        end else if (opc_now == `FSP_CMD_WRSR) begin
                            st_ff <= fsp_pkg::FSP_ST_WDATA;
                        end else begin
                            st_ff <= fsp_pkg::FSP_ST_SKIP;
                        end
                    end
                end
                fsp_pkg::FSP_ST_WDATA: begin
                    if (bcnt_ff == 3'h7) begin
                        wdata_ff <= opc_now;
                        got_data_ff <= 1'b1;
                        st_ff <= fsp_pkg::FSP_ST_SKIP;
                    end
                end
                fsp_pkg::FSP_ST_RDATA: begin
                    st_ff <= fsp_pkg::FSP_ST_RDATA;
                end
                fsp_pkg::FSP_ST_SKIP: begin
                    st_ff <= fsp_pkg::FSP_ST_SKIP;
                end
                default: begin
                    st_ff <= fsp_pkg::FSP_ST_OPC;
                end
            endcase
        end
    end

    // Read data out; byte refreshed each 8 bits so polling sees live busy
    logic [7:0] tx_ff;
    logic [2:0] tcnt_ff;
    logic dq1_ff;
    logic dq1_oe_ff;
    logic [7:0] live_byte;
    logic [7:0] first_byte;

    assign live_byte = (cmd_ff == `FSP_CMD_RDFS) ? flag_status :
                       status_protection_register;
    assign first_byte = (opc_now == `FSP_CMD_RDFS) ? flag_status :
                        status_protection_register;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_ff <= 8'h00;
            tcnt_ff <= 3'h0;
            dq1_ff <= 1'b0;
            dq1_oe_ff <= 1'b0;
        end else if (s_cs_n) begin
            dq1_oe_ff <= 1'b0;
            tcnt_ff <= 3'h0;
        end else if (sck_rise && st_ff == fsp_pkg::FSP_ST_OPC &&
                     bcnt_ff == 3'h7) begin
            tx_ff <= first_byte;
            tcnt_ff <= 3'h0;
        end else if (sck_fall && st_ff == fsp_pkg::FSP_ST_RDATA) begin
            dq1_oe_ff <= 1'b1;
            dq1_ff <= tx_ff[7];
            tcnt_ff <= tcnt_ff + 3'h1;
            if (tcnt_ff == 3'h7) begin
                tx_ff <= live_byte;
            end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    assign spi_dq1_o = dq1_ff;
    assign spi_dq1_oe = dq1_oe_ff;

    // Commands take effect at deselect, once a full opcode has been received
    logic commit;
    logic do_wren;
    logic do_wrdi;
    logic do_wrsr;
    logic do_clfs;

    assign commit = cs_rise & opc_done_ff;
    assign do_wren = commit & (cmd_ff == `FSP_CMD_WREN) & ~busy;
    assign do_wrdi = commit & (cmd_ff == `FSP_CMD_WRDI) & ~busy;
    assign do_clfs = commit & (cmd_ff == `FSP_CMD_CLFS);
    assign do_wrsr = commit & (cmd_ff == `FSP_CMD_WRSR) & got_data_ff &
                     wel_ff & ~busy & ~hw_locked;

    // Program/erase gate
    logic [10:0] tgt_sector;
    logic prot_any;
    logic sec_hit;
    logic is_die;
    logic fire;
    logic blocked;

    assign tgt_sector = req.addr[`FSP_SECTOR_HI:`FSP_SECTOR_LO];

    fsp_prot_decode u_decode (
        .block_protect_bits(blk_prot_ff),
        .tb(tb_ff),
        .sector(tgt_sector),
        .any_set(prot_any),
        .hit(sec_hit)
    );

    // New requests wait until the controller is idle
    assign req_ready = ~busy;
    assign fire = req_valid & req_ready;
    assign is_die = (req.kind == fsp_pkg::FSP_OP_ERASE_DIE);
    assign blocked = is_die ? prot_any : sec_hit;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            op_start <= 1'b0;
            op_reject <= 1'b0;
        end else begin
            op_start <= fire & wel_ff & ~blocked;
            op_reject <= fire & (~wel_ff | blocked);
        end
    end

    // Nonvolatile bits; reset stands in for the power-on load
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {srwd_ff, tb_ff, blk_prot_ff} <= `FSP_SR_NV_RESET;
        end else if (do_wrsr) begin
            srwd_ff <= wdata_ff[`FSP_SR_SRWD];
            tb_ff <= wdata_ff[`FSP_SR_TB];
            blk_prot_ff <= {wdata_ff[`FSP_SR_PROT3],
                            wdata_ff[`FSP_SR_PROT2:`FSP_SR_PROT0]};
        end
    end

    // Latch clears on disable, a committed status write or any accepted request; a same-cycle enable wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wel_ff <= 1'b0;
        end else if (do_wren) begin
            wel_ff <= 1'b1;
        end else if (do_wrdi || do_wrsr || (fire && wel_ff)) begin
            wel_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wtimer_ff <= 8'h00;
        end else if (do_wrsr) begin
            wtimer_ff <= 8'(`FSP_TW_CYC);
        end else if (wtimer_ff != 8'h00) begin
            wtimer_ff <= wtimer_ff - 8'h01;
        end
    end

    // Error flags: a new error wins over a clear in the same cycle
    logic err_set;

    assign err_set = fire & wel_ff & blocked;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prot_err_ff <= 1'b0;
            erase_err_ff <= 1'b0;
            prog_err_ff <= 1'b0;
        end else if (err_set) begin
            prot_err_ff <= 1'b1;
            if (req.kind == fsp_pkg::FSP_OP_PROGRAM) begin
                prog_err_ff <= 1'b1;
            end else begin
                erase_err_ff <= 1'b1;
            end
        end else if (do_clfs) begin
            prot_err_ff <= 1'b0;
            erase_err_ff <= 1'b0;
            prog_err_ff <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// >>> verification/fsp_host.sv
// Serial host model issuing status commands to the flash block
`timescale 1ns/1ns
`default_nettype none
module fsp_host (
    input wire logic clk,
    output var logic spi_sck,
    output var logic spi_cs_n,
    output var logic spi_dq0,
    input wire logic spi_dq1_o,
    input wire logic spi_dq1_oe
);
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_dq0 = 1'b0;
    end
    // Opcode then nb bytes, MSB first; sck rests low between frames
    task automatic xfer(input logic [7:0] op, input logic [7:0] d,
        input int nb, output logic [7:0] r);
        logic [15:0] sh;
        int i;
        sh = {op, d};
        r = 8'h00;
        @(negedge clk);
        spi_cs_n = 1'b0;
        for (i = 0; i < 8 + 8 * nb; i++) begin
            spi_dq0 = sh[15 - i];
            repeat (5) @(negedge clk);
            spi_sck = 1'b1;
            // Undriven line reads as unknown so a silent device fails
            if (i >= 8) r = {r[6:0], spi_dq1_oe ? spi_dq1_o : 1'bx};
            repeat (5) @(negedge clk);
            spi_sck = 1'b0;
        end
        repeat (5) @(negedge clk);
        spi_cs_n = 1'b1;
        spi_dq0 = ~spi_dq0;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verification/fsp_status_protect_checker.sv
// Port assertions for the status/protect block
`timescale 1ns/1ns
`default_nettype none
module fsp_status_protect_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wp_n,
    input wire logic req_valid,
    input wire fsp_pkg::fsp_req_s req,
    input wire logic req_ready,
    input wire logic op_start,
    input wire logic op_reject,
    input wire logic op_active,
    input wire logic write_enable_latch,
    input wire logic [7:0] status_protection_register,
    input wire logic [7:0] flag_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic [7:0] sr;
    assign take = req_valid && req_ready;
    assign sr = status_protection_register;
    a_busy_inverse: assert property (sr[0] != flag_status[7])
        else $error("busy equals ready flag");
    a_ready_flag: assert property (flag_status[7] == req_ready)
        else $error("ready flag wrong");
    a_engine_busy: assert property (op_active |-> !req_ready && sr[0])
        else $error("not busy while engine runs");
    a_no_take: assert property (!take |=> !op_start && !op_reject)
        else $error("result without request");
    a_no_wel: assert property (take && !write_enable_latch |=> op_reject)
        else $error("request without latch not refused");
    a_wel_clear: assert property (take && write_enable_latch |=>
        !write_enable_latch)
        else $error("latch kept after request");
    a_die_block: assert property (take && req.kind ==
        fsp_pkg::FSP_OP_ERASE_DIE && |{sr[6], sr[4:2]} |=> op_reject)
        else $error("die erase not refused");
    a_full_prot: assert property (take && sr[6] && sr[4] |=> op_reject)
        else $error("full protection not refused");
    a_prot_flag: assert property (op_reject && $past(write_enable_latch)
        |-> flag_status[1])
        else $error("protection flag not set");
    a_wp_lock: assert property (sr[7] && !wp_n && !$past(wp_n) &&
        !$past(wp_n, 2) |=> $stable(sr[7:2]))
        else $error("locked status changed");
endmodule
bind fsp_status_protect fsp_status_protect_checker
    u_fsp_status_protect_checker (.clk, .reset_n, .wp_n, .req_valid, .req,
    .req_ready, .op_start, .op_reject, .op_active, .write_enable_latch,
    .status_protection_register, .flag_status);
`default_nettype wire

// >>> verification/tb_fsp_status_protect.sv
// Self-checking bench for the status/protect block
`include "fsp_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_fsp_status_protect;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic req_valid = 1'b0;
    fsp_pkg::fsp_req_s req = '0;
    logic spi_sck, spi_cs_n, spi_dq0, spi_dq1_o, spi_dq1_oe;
    logic req_ready, op_start, op_reject, op_active;
    logic [7:0] sr, fs;
    logic [2:0] act_cnt = 3'h0;
    bit exp_q[$];
    int miscompares = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    assign op_active = act_cnt != 3'h0;
    // Engine stand-in, busy a few cycles per started operation
    always @(posedge clk) begin
        if (op_start === 1'b1) act_cnt <= 3'h5;
        else if (op_active) act_cnt <= act_cnt - 3'h1;
    end
    fsp_status_protect u_fsp_status_protect (.clk, .reset_n, .spi_sck,
        .spi_cs_n, .spi_dq0, .spi_dq1_o, .spi_dq1_oe, .wp_n, .req_valid,
        .req, .req_ready, .op_start, .op_reject, .op_active,
        .write_enable_latch(), .status_protection_register(sr),
        .flag_status(fs));
    fsp_host u_fsp_host (.clk, .spi_sck, .spi_cs_n, .spi_dq0, .spi_dq1_o,
        .spi_dq1_oe);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (exp_q.size() != 0) miscompares++;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic idle;
        int k;
        for (k = 0; k < 300 && sr[0] !== 1'b0; k++) @(negedge clk);
        if (k == 300) begin
            miscompares++;
            end_sim;
        end
    endtask
    task automatic rd(input logic [7:0] op, input logic [7:0] e);
        logic [7:0] r;
        u_fsp_host.xfer(op, 8'h00, 1, r);
        chk(r, e);
    endtask
    // Latch then status write; ok says whether it must commit
    task automatic wsr(input logic [7:0] v, input bit ok);
        logic [7:0] r;
        u_fsp_host.xfer(`FSP_CMD_WREN, 8'h00, 0, r);
        u_fsp_host.xfer(`FSP_CMD_WRSR, v, 1, r);
        chk({7'h0, sr[0]}, {7'h0, ok});
        idle;
    endtask
    task automatic req_op(input logic [2:0] k, input logic [10:0] s,
        input bit e, input bit wen);
        logic [7:0] r;
        bit b;
        b = wen & ~e;
        if (wen) u_fsp_host.xfer(`FSP_CMD_WREN, 8'h00, 0, r);
        exp_q.push_back(e);
        @(negedge clk);
        req_valid = 1'b1;
        req.kind = fsp_pkg::fsp_op_e'(k);
        req.addr = {s, 16'($urandom)};
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
        chk({7'h0, fs[1]}, {7'h0, wen & ~e});
        rd(`FSP_CMD_RDFS, {1'h1, 1'h0, b & (k != 3'h0), b & (k == 3'h0),
            2'h0, b, 1'h0});
        u_fsp_host.xfer(`FSP_CMD_CLFS, 8'h00, 0, r);
        idle;
        chk(fs, 8'h80);
    endtask
    always @(posedge clk) begin
        if (op_start === 1'b1 || op_reject === 1'b1) begin
            if (exp_q.size() == 0) miscompares++;
            else chk({7'h0, op_start}, {7'h0, exp_q.pop_front()});
        end
    end
    initial begin
        int c;
        int n;
        bit in;
        bit e;
        logic [10:0] s;
        logic [3:0] code;
        logic [7:0] r;
        void'($urandom(65295));
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(fs, 8'h80);
        rd(`FSP_CMD_RDSR, 8'h00);
        req_op(3'h0, 11'h000, 0, 0);
        // Each code at both anchors; codes 1-11 target just inside or outside
        for (c = 0; c < 32; c++) begin
            code = c[3:0];
            n = 1 << (code - 1);
            in = 1'($urandom);
            s = 11'($urandom);
            e = code == 0;
            if (code != 0 && code < 12) begin
                e = !in;
                if (c[4]) s = 11'(in ? n - 1 : n);
                else s = 11'(in ? 2048 - n : 2047 - n);
            end
            wsr({1'h0, code[3], c[4], code[2:0], 2'h0}, 1);
            rd(`FSP_CMD_RDSR, {1'h0, code[3], c[4], code[2:0], 2'h0});
            req_op(3'($urandom % 4), s, e, 1);
        end
        req_op(3'h4, 11'h000, 0, 1);
        wsr(8'h80, 1);
        wp_n = 1'b0;
        wsr(8'h1C, 0);
        rd(`FSP_CMD_RDSR, 8'h82);
        wp_n = 1'b1;
        wsr(8'h00, 1);
        rd(`FSP_CMD_RDSR, 8'h00);
        req_op(3'h4, 11'h000, 1, 1);
        u_fsp_host.xfer(`FSP_CMD_WREN, 8'h00, 0, r);
        rd(`FSP_CMD_RDSR, 8'h02);
        u_fsp_host.xfer(`FSP_CMD_WRDI, 8'h00, 0, r);
        rd(`FSP_CMD_RDSR, 8'h00);
        // Latch set again, then a reset must clear it
        u_fsp_host.xfer(`FSP_CMD_WREN, 8'h00, 0, r);
        reset_n = 1'b0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(`FSP_CMD_RDSR, 8'h00);
        end_sim;
    end
    initial begin
        #1000000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
